// ### verilog/dctd_consts.svh
// Purpose: named offsets, bit positions and counts of the dual counter block
// Assumes: included by the design module only
// Notes: definitions only
//
// Notes on behaviour
// RULE_01 - modulo mode reloads, single-pass mode stops
// RULE_02 - edge detector pulses on qualifying edges
// RULE_03 - edge select: falling, rising, both
// RULE_04 - glitch filter: none, four, eight cycles
// RULE_05 - idle counter A output inverts initial bit
// RULE_06 - outputs take initial bit at start
// RULE_07 - submode: normal, ping-pong, force B low/high
// RULE_08 - combined pin: AND, OR, NOR, NAND
// RULE_09 - pin enables route counter outputs out
// RULE_10 - input select and mode select bits
// RULE_11 - edge flags set, write one clears
// RULE_12 - software stops, sets single-pass, then enables
// RULE_13 - initial count not one; restart reloads
// RULE_14 - ping-pong alternates enables in hardware
// RULE_15 - ping-pong sets timeout at each terminal
// RULE_16 - timeout cleared only by writing one
// RULE_17 - counter B clock divide by 1/2/4/8
// RULE_18 - other counter starts next counting clock
// RULE_19 - reserved low bits read ones, ignore writes
`ifndef DCTD_CONSTS_SVH
`define DCTD_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define DCTD_OFF_ACTL 8'h00
`define DCTD_OFF_CMN 8'h01
`define DCTD_OFF_BCTL 8'h02
`define DCTD_OFF_XCTL 8'h03
`define DCTD_OFF_ALOAD 8'h04
`define DCTD_OFF_BLOADL 8'h05
`define DCTD_OFF_BLOADH 8'h06
`define DCTD_OFF_IRQ_ST 8'h07
`define DCTD_OFF_IRQ_EN 8'h08
`define DCTD_OFF_IRQ_CLR 8'h09

// ****************************************
// field positions
// ****************************************
`define DCTD_B_EN 7
`define DCTD_B_SINGLE 6
`define DCTD_B_TOUT 5
`define DCTD_B_PIN 0
`define DCTD_B_CMN_MODE 7
`define DCTD_B_CMN_SEL 6
`define DCTD_B_CMN_INIT_A 1
`define DCTD_B_CMN_INIT_B 0
`define DCTD_IRQ_TOUT_A 0
`define DCTD_IRQ_TOUT_B 1
`define DCTD_IRQ_RISE 2
`define DCTD_IRQ_FALL 3

// ****************************************
// values and counts
// ****************************************
`define DCTD_XCTL_RSVD 5'h1f
`define DCTD_TERM_COUNT 1
`define DCTD_FILT_SHORT 4'h4
`define DCTD_FILT_LONG 4'h8
`define DCTD_FILT_NONE 4'h0

`endif

// ### verilog/dctd_pkg.sv
// Purpose: shared types of the dual counter block
// Assumes: dctd_consts.svh holds the numbers
// Notes: field codes follow the common control register
`default_nettype none
package dctd_pkg;
	typedef enum logic [1:0] {DCTD_SUB_NORMAL = 2'h0, DCTD_SUB_PINGPONG = 2'h1,
		DCTD_SUB_FORCE0 = 2'h2, DCTD_SUB_FORCE1 = 2'h3} dctd_sub_t;
	typedef enum logic [1:0] {DCTD_LOG_AND = 2'h0, DCTD_LOG_OR = 2'h1,
		DCTD_LOG_NOR = 2'h2, DCTD_LOG_NAND = 2'h3} dctd_logic_t;
	typedef enum logic [1:0] {DCTD_EDGE_FALL = 2'h0, DCTD_EDGE_RISE = 2'h1,
		DCTD_EDGE_BOTH = 2'h2, DCTD_EDGE_RSVD = 2'h3} dctd_edge_t;
endpackage
`default_nettype wire

// ### verilog/dctd_top.sv
// Purpose: two down-counters with transmit outputs and an edge demodulator
// Assumes: one clock mclk, registers on a plain strobe port
// Notes: counter A runs on mclk, counter B on a divided tick
//
// Our own choice: the strobed register port.
`include "dctd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dctd_top
	import dctd_pkg::*;
#(
	parameter int A_W = 8,
	parameter int B_W = 16,
	parameter int IRQ_W = 4
)(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic first_input_pin,
	input wire logic second_input_pin,
	output logic first_output_pin,
	output logic first_output_sel,
	output logic second_output_pin,
	output logic second_output_sel,
	output logic combined_output_pin,
	output logic combined_output_sel,
	output logic pos_edge,
	output logic neg_edge,
	output logic irq
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic a_en;
		logic a_single;
		logic a_tout;
		logic [3:0] a_misc;
		logic a_pin;
		logic a_ran;
		logic a_pend;
		logic [A_W-1:0] load_a;
		logic [A_W-1:0] cnt_a;
		logic out_a;
		logic b_en;
		logic b_single;
		logic b_tout;
		logic [1:0] b_clk;
		logic [1:0] b_misc;
		logic b_pin;
		logic b_ran;
		logic b_pend;
		logic [B_W-1:0] load_b;
		logic [B_W-1:0] cnt_b;
		logic out_b;
		logic [2:0] pre;
		logic mode;
		logic sel;
		logic [1:0] logic_f;
		logic [1:0] sub;
		logic init_a;
		logic init_b;
		logic rise_f;
		logic fall_f;
		logic [2:0] x_hi;
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] in_v;
		logic [3:0] filt_cnt;
		logic filt_v;
		logic pos;
		logic neg;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_en;
		logic [7:0] rdata;
		logic p1;
		logic p2;
		logic p3;
	} dctd_state_t;

	dctd_state_t st_q;
	dctd_state_t st_d;

	// ****************************************
	// functions
	// ****************************************
	function automatic logic div_tick(input logic [2:0] pre, input logic [1:0] sel);
		logic t;
		t = 1'b1;
		case (sel)
			2'h0: t = 1'b1;
			2'h1: t = pre[0];
			2'h2: t = &pre[1:0];
			default: t = &pre;
		endcase
		return t;
	endfunction

	function automatic logic [3:0] filt_len(input logic [1:0] code);
		logic [3:0] n;
		n = `DCTD_FILT_NONE;
		case (code)
			2'h1: n = `DCTD_FILT_SHORT;
			2'h2: n = `DCTD_FILT_LONG;
			default: n = `DCTD_FILT_NONE;
		endcase
		return n;
	endfunction

	function automatic logic combine(input logic a, input logic b, input logic [1:0] op);
		logic r;
		r = 1'b0;
		case (op)
			DCTD_LOG_AND: r = a & b;
			DCTD_LOG_OR: r = a | b;
			DCTD_LOG_NOR: r = ~(a | b);
			default: r = ~(a & b);
		endcase
		return r;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		logic wr_actl;
		logic wr_cmn;
		logic wr_bctl;
		logic start_a;
		logic start_b;
		logic tc_a;
		logic tc_b;
		logic tick_b;
		logic ping;
		logic raw;
		logic b_eff;
		logic [3:0] flen;
		logic [IRQ_W-1:0] ev;
		st_d = st_q;
		wr_actl = reg_wr && (reg_addr == `DCTD_OFF_ACTL);
		wr_cmn = reg_wr && (reg_addr == `DCTD_OFF_CMN);
		wr_bctl = reg_wr && (reg_addr == `DCTD_OFF_BCTL);
		start_a = 1'b0;
		start_b = 1'b0;
		tc_a = 1'b0;
		tc_b = 1'b0;
		ev = '0;
		raw = 1'b0;
		b_eff = 1'b0;
		flen = '0;
		st_d.pre = 3'(st_q.pre + 3'h1);
		tick_b = div_tick(st_q.pre, st_q.b_clk); // [RULE_17]
		ping = !st_q.mode && (st_q.sub == DCTD_SUB_PINGPONG);
		// software writes
		if (wr_actl)
		begin
			st_d.a_single = reg_wdata[`DCTD_B_SINGLE];
			st_d.a_misc = reg_wdata[4:1];
			st_d.a_pin = reg_wdata[`DCTD_B_PIN];
			if (reg_wdata[`DCTD_B_TOUT])
				st_d.a_tout = 1'b0; // [RULE_16]
			if (reg_wdata[`DCTD_B_EN] && !st_q.a_en)
				start_a = 1'b1;
			else if (!reg_wdata[`DCTD_B_EN])
			begin
				st_d.a_en = 1'b0;
				st_d.a_ran = 1'b0;
			end
		end
		if (wr_bctl)
		begin
			st_d.b_single = reg_wdata[`DCTD_B_SINGLE];
			st_d.b_clk = reg_wdata[4:3];
			st_d.b_misc = reg_wdata[2:1];
			st_d.b_pin = reg_wdata[`DCTD_B_PIN];
			if (reg_wdata[`DCTD_B_TOUT])
				st_d.b_tout = 1'b0; // [RULE_16]
			if (reg_wdata[`DCTD_B_EN] && !st_q.b_en)
				start_b = 1'b1;
			else if (!reg_wdata[`DCTD_B_EN])
			begin
				st_d.b_en = 1'b0;
				st_d.b_ran = 1'b0;
			end
		end
		if (wr_cmn)
		begin
			st_d.mode = reg_wdata[`DCTD_B_CMN_MODE]; // [RULE_10]
			st_d.sel = reg_wdata[`DCTD_B_CMN_SEL];
			st_d.logic_f = reg_wdata[5:4];
			st_d.sub = reg_wdata[3:2];
			if (!st_q.mode)
			begin
				st_d.init_a = reg_wdata[`DCTD_B_CMN_INIT_A];
				st_d.init_b = reg_wdata[`DCTD_B_CMN_INIT_B];
			end
			else
			begin
				if (reg_wdata[`DCTD_B_CMN_INIT_A])
					st_d.rise_f = 1'b0; // [RULE_11]
				if (reg_wdata[`DCTD_B_CMN_INIT_B])
					st_d.fall_f = 1'b0; // [RULE_11]
			end
		end
		// counter A
		if (st_q.a_en && st_d.a_en && !start_a)
		begin
			if (st_q.cnt_a == A_W'(`DCTD_TERM_COUNT))
			begin
				tc_a = 1'b1;
				st_d.out_a = ~st_q.out_a;
				st_d.cnt_a = st_q.load_a; // [RULE_01]
				if (st_q.a_single)
				begin
					st_d.a_en = 1'b0; // [RULE_01] [RULE_14]
					if (ping)
						st_d.b_pend = 1'b1; // [RULE_18]
				end
			end
			else
				st_d.cnt_a = A_W'(st_q.cnt_a - 1'b1);
		end
		// counter B, counting on its divided tick
		if (st_q.b_en && st_d.b_en && !start_b && tick_b)
		begin
			if (st_q.cnt_b == B_W'(`DCTD_TERM_COUNT))
			begin
				tc_b = 1'b1;
				st_d.out_b = ~st_q.out_b;
				st_d.cnt_b = st_q.load_b; // [RULE_01]
				if (st_q.b_single)
				begin
					st_d.b_en = 1'b0; // [RULE_01] [RULE_14]
					if (ping)
						st_d.a_pend = 1'b1; // [RULE_18]
				end
			end
			else
				st_d.cnt_b = B_W'(st_q.cnt_b - 1'b1);
		end
		// ping-pong handover, counter A counts on every mclk edge
		if (st_q.a_pend)
		begin
			st_d.a_pend = 1'b0;
			if (ping)
				start_a = 1'b1; // [RULE_14] [RULE_18]
		end
		if (st_q.b_pend && tick_b)
		begin
			st_d.b_pend = 1'b0;
			if (ping)
				start_b = 1'b1; // [RULE_14] [RULE_18]
		end
		if (!ping)
		begin
			st_d.a_pend = 1'b0;
			st_d.b_pend = 1'b0;
		end
		// a start always reloads, so a restart never resumes a stale count
		if (start_a)
		begin
			st_d.a_en = 1'b1;
			st_d.a_ran = 1'b1;
			st_d.cnt_a = st_q.load_a; // [RULE_13]
			st_d.out_a = st_d.init_a; // [RULE_06]
		end
		if (start_b)
		begin
			st_d.b_en = 1'b1;
			st_d.b_ran = 1'b1;
			st_d.cnt_b = st_q.load_b; // [RULE_13]
			st_d.out_b = st_d.init_b; // [RULE_06]
		end
		if (!st_d.a_en && !st_d.a_ran)
			st_d.out_a = ~st_d.init_a; // [RULE_05]
		if (!st_d.b_en && !st_d.b_ran)
			st_d.out_b = ~st_d.init_b;
		// timeout set wins over a clear in the same cycle
		if (tc_a)
			st_d.a_tout = 1'b1; // [RULE_15]
		if (tc_b)
			st_d.b_tout = 1'b1; // [RULE_15]
		// load registers
		if (reg_wr && (reg_addr == `DCTD_OFF_ALOAD))
			st_d.load_a = reg_wdata[A_W-1:0];
		if (reg_wr && (reg_addr == `DCTD_OFF_BLOADL))
			st_d.load_b[7:0] = reg_wdata;
		if (reg_wr && (reg_addr == `DCTD_OFF_BLOADH))
			st_d.load_b[B_W-1:8] = reg_wdata[B_W-9:0];
		if (reg_wr && (reg_addr == `DCTD_OFF_XCTL))
			st_d.x_hi = reg_wdata[7:5]; // [RULE_19]
		// input synchroniser, value counts once stages two and three agree
		st_d.s1 = {second_input_pin, first_input_pin};
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2[0] == st_q.s3[0])
			st_d.in_v[0] = st_q.s3[0];
		if (st_q.s2[1] == st_q.s3[1])
			st_d.in_v[1] = st_q.s3[1];
		// glitch filter on the selected input
		raw = st_q.sel ? st_q.in_v[1] : st_q.in_v[0]; // [RULE_10] [RULE_02]
		flen = filt_len(st_q.sub); // [RULE_04]
		st_d.pos = 1'b0;
		st_d.neg = 1'b0;
		if (raw == st_q.filt_v)
			st_d.filt_cnt = '0;
		else if (4'(st_q.filt_cnt + 4'h1) >= flen)
		begin
			st_d.filt_cnt = '0;
			st_d.filt_v = raw; // [RULE_04]
			if (st_q.mode)
			begin
				if (raw && (st_q.logic_f == DCTD_EDGE_RISE || st_q.logic_f == DCTD_EDGE_BOTH))
					st_d.pos = 1'b1; // [RULE_02] [RULE_03]
				if (!raw && (st_q.logic_f == DCTD_EDGE_FALL || st_q.logic_f == DCTD_EDGE_BOTH))
					st_d.neg = 1'b1; // [RULE_02] [RULE_03]
			end
		end
		else
			st_d.filt_cnt = 4'(st_q.filt_cnt + 4'h1);
		if (st_d.pos)
			st_d.rise_f = 1'b1; // [RULE_11]
		if (st_d.neg)
			st_d.fall_f = 1'b1; // [RULE_11]
		// interrupt status, set wins over clear
		ev[`DCTD_IRQ_TOUT_A] = tc_a;
		ev[`DCTD_IRQ_TOUT_B] = tc_b;
		ev[`DCTD_IRQ_RISE] = st_d.pos;
		ev[`DCTD_IRQ_FALL] = st_d.neg;
		if (reg_wr && (reg_addr == `DCTD_OFF_IRQ_CLR))
			st_d.irq_st = st_q.irq_st & ~reg_wdata[IRQ_W-1:0];
		st_d.irq_st = st_d.irq_st | ev;
		if (reg_wr && (reg_addr == `DCTD_OFF_IRQ_EN))
			st_d.irq_en = reg_wdata[IRQ_W-1:0];
		// pins
		b_eff = st_q.out_b;
		if (!st_q.mode && st_q.sub == DCTD_SUB_FORCE0)
			b_eff = 1'b0; // [RULE_07]
		if (!st_q.mode && st_q.sub == DCTD_SUB_FORCE1)
			b_eff = 1'b1; // [RULE_07]
		st_d.p1 = st_q.a_pin & st_q.out_a; // [RULE_09]
		st_d.p2 = st_q.b_pin & b_eff; // [RULE_09]
		st_d.p3 = !st_q.mode && st_q.sel && combine(st_q.out_a, b_eff, st_q.logic_f); // [RULE_08]
		// read data, present only in the cycle after the strobe
		st_d.rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				`DCTD_OFF_ACTL: st_d.rdata = {st_q.a_en, st_q.a_single, st_q.a_tout,
					st_q.a_misc, st_q.a_pin};
				`DCTD_OFF_CMN: st_d.rdata = {st_q.mode, st_q.sel, st_q.logic_f, st_q.sub,
					st_q.mode ? st_q.rise_f : st_q.init_a,
					st_q.mode ? st_q.fall_f : st_q.init_b};
				`DCTD_OFF_BCTL: st_d.rdata = {st_q.b_en, st_q.b_single, st_q.b_tout,
					st_q.b_clk, st_q.b_misc, st_q.b_pin};
				`DCTD_OFF_XCTL: st_d.rdata = {st_q.x_hi, `DCTD_XCTL_RSVD}; // [RULE_19]
				`DCTD_OFF_ALOAD: st_d.rdata = 8'(st_q.load_a);
				`DCTD_OFF_BLOADL: st_d.rdata = st_q.load_b[7:0];
				`DCTD_OFF_BLOADH: st_d.rdata = 8'(st_q.load_b[B_W-1:8]);
				`DCTD_OFF_IRQ_ST: st_d.rdata = 8'(st_q.irq_st);
				`DCTD_OFF_IRQ_EN: st_d.rdata = 8'(st_q.irq_en);
				default: st_d.rdata = '0;
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rdata = st_q.rdata;
	assign first_output_pin = st_q.p1;
	assign first_output_sel = st_q.a_pin;
	assign second_output_pin = st_q.p2;
	assign second_output_sel = st_q.b_pin;
	assign combined_output_pin = st_q.p3;
	assign combined_output_sel = !st_q.mode && st_q.sel;
	assign pos_edge = st_q.pos;
	assign neg_edge = st_q.neg;
	assign irq = |(st_q.irq_st & st_q.irq_en);
endmodule
`default_nettype wire

// ### verif/dctd_sva.sv
// Purpose: port checks of the dual counter block
// Assumes: one clock mclk, reset rst_b
// Notes: bound to dctd_top at the foot
`timescale 1ns/1ps
`default_nettype none
module dctd_sva (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic first_output_pin,
	input wire logic first_output_sel,
	input wire logic second_output_pin,
	input wire logic second_output_sel,
	input wire logic combined_output_pin,
	input wire logic combined_output_sel,
	input wire logic pos_edge,
	input wire logic neg_edge,
	input wire logic irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// ********
	// checks
	// ********
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	rsvd_ones_a: assert property (
		$past(reg_rd) && $past(reg_addr) == 8'h03 |-> reg_rdata[4:0] == 5'h1f)
		else $error("reserved bits not ones");
	// pins trail their selects by one cycle, so the select is taken one cycle back
	pin_a_gate_a: assert property (
		!$past(first_output_sel) |-> !first_output_pin)
		else $error("first pin driven while not owned");
	pin_b_gate_a: assert property (
		!$past(second_output_sel) |-> !second_output_pin)
		else $error("second pin driven while not owned");
	comb_gate_a: assert property (!$past(combined_output_sel) |-> !combined_output_pin)
		else $error("combined pin driven while off");
	pos_one_a: assert property (pos_edge |=> !pos_edge)
		else $error("rise pulse too long");
	neg_one_a: assert property (neg_edge |=> !neg_edge)
		else $error("fall pulse too long");
	edge_excl_a: assert property (!(pos_edge && neg_edge))
		else $error("both edge pulses at once");
	irq_mask_a: assert property (
		$past(reg_wr) && $past(reg_addr) == 8'h08 && $past(reg_wdata) == 8'h00 |-> !irq)
		else $error("irq high with all masked");
	cover property (pos_edge);
	cover property (neg_edge);
	cover property (irq);
	cover property (combined_output_sel);
endmodule
bind dctd_top dctd_sva chk (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .first_output_pin, .first_output_sel, .second_output_pin,
	.second_output_sel, .combined_output_pin, .combined_output_sel, .pos_edge,
	.neg_edge, .irq);
`default_nettype wire

// ### verif/dctd_pins.sv
// Purpose: model of the two demodulator input pins
// Assumes: paced by the bench clock
// Notes: pins idle low between pulses
`timescale 1ns/1ps
`default_nettype none
module dctd_pins (
	input wire logic mclk,
	output var logic [1:0] line_q
);
	// ********
	// pulse driver
	// ********
	initial line_q = 2'h0;
	task automatic pulse(input int idx, input int w);
		@(posedge mclk);
		line_q[idx] <= 1'b1;
		repeat (w) @(posedge mclk);
		line_q[idx] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Purpose: self-checking bench of dctd_top
// Assumes: dctd_pins drives the input pins
// Notes: registers reached by the strobe port only
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] v;
	logic [1:0] pins;
	logic o1, e1, o2, e2, o3, e3, pos_edge, neg_edge, irq;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	always #20 mclk = ~mclk;
	dctd_top uut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.first_input_pin(pins[0]), .second_input_pin(pins[1]),
		.first_output_pin(o1), .first_output_sel(e1), .second_output_pin(o2),
		.second_output_sel(e2), .combined_output_pin(o3), .combined_output_sel(e3),
		.pos_edge, .neg_edge, .irq);
	dctd_pins pm (.mclk, .line_q(pins));
	// ********
	// bus and compare
	// ********
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// cycles that the first or second pin stays at one level, bounded
	task automatic hold(input logic lv, input bit use_b);
		n = 0;
		while (((use_b ? o2 : o1) === lv) && n < 20)
		begin
			tick(1);
			n++;
		end
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_regs();
		rd(8'h01);
		chk("common", 8'h00, v);
		rd(8'h03);
		chk("xctl", 8'h1f, v);
		wr(8'h03, 8'h40);
		rd(8'h03);
		chk("xctl", 8'h5f, v);
		rd(8'h5a);
		chk("unmapped", 8'h00, v);
	endtask
	task automatic t_count();
		wr(8'h00, 8'h01);
		tick(2);
		chk1("idle a", 1'b1, o1);
		wr(8'h01, 8'h02);
		tick(2);
		chk1("idle a", 1'b0, o1);
		wr(8'h04, 8'h03);
		wr(8'h00, 8'h81);
		tick(2);
		chk1("start a", 1'b1, o1);
		hold(1'b1, 1'b0);
		hold(1'b0, 1'b0);
		chk("half period", 8'h03, 8'(n));
		rd(8'h00);
		chk("ctl a", 8'ha1, v);
		// stop and clear land between terminals with a load of three
		wr(8'h00, 8'h21);
		rd(8'h00);
		chk("ctl a", 8'h01, v);
		rd(8'h07);
		chk("status", 8'h01, v);
		wr(8'h08, 8'h01);
		tick(1);
		chk1("irq", 1'b1, irq);
		wr(8'h08, 8'h00);
		tick(1);
		chk1("irq", 1'b0, irq);
		wr(8'h08, 8'h01);
		wr(8'h09, 8'h01);
		tick(1);
		chk1("irq", 1'b0, irq);
		wr(8'h00, 8'hc1);
		tick(8);
		rd(8'h00);
		chk("ctl a", 8'h61, v);
	endtask
	task automatic t_pong();
		int na = 0;
		int nb = 0;
		logic la;
		logic lb;
		wr(8'h00, 8'h61);
		wr(8'h02, 8'h41);
		wr(8'h05, 8'h04);
		wr(8'h06, 8'h00);
		wr(8'h01, 8'h04);
		wr(8'h00, 8'hc1);
		la = o1;
		lb = o2;
		repeat (80)
		begin
			tick(1);
			na += int'(o1 !== la);
			nb += int'(o2 !== lb);
			la = o1;
			lb = o2;
		end
		chk1("a ran", 1'b1, na > 2);
		chk1("b ran", 1'b1, nb > 2);
		rd(8'h00);
		chk1("a tout", 1'b1, v[5]);
		rd(8'h02);
		chk1("b tout", 1'b1, v[5]);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h01);
		wr(8'h02, 8'h01);
	endtask
	task automatic t_div();
		// counter B modulo on a divide-by-two tick, load of four
		wr(8'h02, 8'h89);
		tick(2);
		chk1("start b", 1'b0, o2);
		hold(1'b0, 1'b1);
		hold(1'b1, 1'b1);
		chk("b half period", 8'h08, 8'(n));
		wr(8'h02, 8'h01);
	endtask
	task automatic t_comb();
		// idle outputs: a low, b high
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h01, 8'h42 | 8'(k << 4));
			tick(2);
			chk1("comb pin", k[0], o3);
			chk1("comb sel", 1'b1, e3);
		end
		chk1("b pin", 1'b1, o2);
		wr(8'h01, 8'h4a);
		tick(2);
		chk1("b forced", 1'b0, o2);
		wr(8'h01, 8'h4e);
		tick(2);
		chk1("b forced", 1'b1, o2);
		chk1("a sel", 1'b1, e1);
		chk1("b sel", 1'b1, e2);
		// releasing the pin while the forced output is high
		wr(8'h02, 8'h00);
		tick(2);
		chk1("b sel", 1'b0, e2);
		chk1("b pin", 1'b0, o2);
	endtask
	task automatic edge_try(input logic [7:0] cm, input int p, input int w,
		input int ep, input int en);
		int np = 0;
		int nn = 0;
		wr(8'h01, cm);
		fork
			pm.pulse(p, w);
			repeat (w + 30)
			begin
				tick(1);
				np += int'(pos_edge === 1'b1);
				nn += int'(neg_edge === 1'b1);
			end
		join
		chk("rises", 8'(ep), 8'(np));
		chk("falls", 8'(en), 8'(nn));
	endtask
	task automatic t_demod();
		edge_try(8'h80, 0, 6, 0, 1);
		edge_try(8'h90, 0, 6, 1, 0);
		edge_try(8'ha0, 0, 6, 1, 1);
		edge_try(8'ha4, 0, 2, 0, 0);
		edge_try(8'ha4, 0, 8, 1, 1);
		edge_try(8'ha8, 0, 5, 0, 0);
		edge_try(8'ha8, 0, 12, 1, 1);
		edge_try(8'he0, 0, 6, 0, 0);
		edge_try(8'he0, 1, 6, 1, 1);
		rd(8'h01);
		chk("flags", 8'he3, v);
		wr(8'h01, 8'he0);
		rd(8'h01);
		chk("flags", 8'he3, v);
		wr(8'h01, 8'he3);
		rd(8'h01);
		chk("flags", 8'he0, v);
		edge_try(8'h20, 0, 6, 0, 0);
	endtask
	// a hang is cut off far beyond the six hundred or so cycles the tests take
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares = miscompares + 1;
			close_out();
		end
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		t_regs();
		t_count();
		t_pong();
		t_div();
		t_comb();
		t_demod();
		close_out();
	end
endmodule
`default_nettype wire
